// file: core/flag_status_consts.vh
// Constants for the host flag and status emulator
`ifndef FLAG_STATUS_CONSTS_VH
`define FLAG_STATUS_CONSTS_VH
// Host I/O block
`define IO_BLOCK_BASE 10'h220
`define IO_BLOCK_LAST 10'h22F
`define IO_CMD_FLAG_ADDR 10'h226
`define IO_FLAG_STAT_ADDR 10'h227
// Main status bit positions
`define MS_AUX_CHANGE 7
`define MS_TRIGGER 6
`define MS_KEY_EMPTY 5
`define MS_FATAL 4
`define MS_UNIT_RESET 3
`define MS_CMD_IRQ 2
`define MS_BUF_MOD 1
`define MS_CURSOR_SET 0
// Flag byte bit positions
`define FLAG_ATTN_BIT 7
`define FLAG_CMD_BIT 6
// Register offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MAIN 8'h08
`define REG_AUX 8'h0C
`define REG_TRIG_ADDR 8'h10
`define REG_TRIG_DATA 8'h14
`define REG_ATTN_MASK 8'h18
`define REG_IRQ_STAT 8'h1C
`define REG_IRQ_MASK 8'h20
`define REG_HOST_ADDR 8'h24
`define REG_COAX_IN 8'h28
// Control bits
`define CTRL_RELEASE 0
`define CTRL_CMD_DONE 1
`define CTRL_MAIN_CLR_LO 8
// Aux build mask on coax main status
`define AUX_COAX_MASK 8'h40
`define RESET_BYTE 8'h00
// Refresh interval in clocks
`define REFRESH_CYCLES 8'd16
`endif

// file: core/host_write_catch.v
// Host I/O block write capture and lockout
`timescale 1ns/1ps
`default_nettype none
`include "flag_status_consts.vh"
module host_write_catch (
   // Clock and reset
   input wire clock,
   input wire reset,
   // Host bus
   input wire host_wr,
   input wire [9:0] host_addr,
   // Release and capture
   input wire release_lock,
   output reg pending_n_q,
   output reg [3:0] host_offset_q
);
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         pending_n_q <= 1'b1;
         host_offset_q <= 4'h0;
      end else if (release_lock) begin
         pending_n_q <= 1'b1;
      end else if (pending_n_q && host_wr && host_addr >= `IO_BLOCK_BASE &&
                   host_addr <= `IO_BLOCK_LAST) begin
         pending_n_q <= 1'b0;
         host_offset_q <= host_addr[3:0];
      end
   end
endmodule
`default_nettype wire

// file: core/trigger_match.v
// Trigger compare on screen buffer byte
`timescale 1ns/1ps
`default_nettype none
`include "flag_status_consts.vh"
module trigger_match (
   // Clock and reset
   input wire clock,
   input wire reset,
   // Trigger setup
   input wire [7:0] trig_data,
   input wire [7:0] trig_mask,
   // Screen byte
   input wire [7:0] screen_byte,
   input wire sample,
   output wire hit
);
   reg [7:0] last_q;
   always @(posedge clock or posedge reset) begin
      if (reset)
         last_q <= `RESET_BYTE;
      else if (sample)
         last_q <= screen_byte;
   end
   // Zero mask means any change of the byte
   assign hit = (trig_mask == 8'h00) ? (screen_byte != last_q) :
                (((screen_byte ^ trig_data) & trig_mask) == 8'h00);
endmodule
`default_nettype wire

// file: core/host_flag_status_emulator.v
// Host flag and status emulator top with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "flag_status_consts.vh"
module host_flag_status_emulator (
   // Clock and reset
   input wire clock,
   input wire reset,
   // Host I/O bus
   input wire host_wr,
   input wire host_rd,
   input wire [9:0] host_addr,
   output reg host_lock_q,
   output reg [7:0] host_rdata_q,
   // Coax and screen side
   input wire [7:0] coax_main_status,
   input wire [7:0] controller_state_byte,
   input wire [7:0] screen_byte,
   output reg [7:0] screen_addr_q,
   // Flag outputs
   output reg cmd_flag_q,
   output reg attn_flag_q,
   output reg pending_n_q,
   output reg irq_q,
   // AXI4-Lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   reg [7:0] main_q;
   reg [7:0] aux_q;
   reg [7:0] trig_addr_q;
   reg [7:0] trig_data_q;
   reg [7:0] trig_mask_q;
   reg [7:0] attn_mask_q;
   reg [2:0] irq_stat_q;
   reg [2:0] irq_mask_q;
   reg [7:0] refresh_q;
   reg [7:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg aw_have_q;
   reg w_have_q;
   wire pend_n;
   wire refresh_tick;
   wire [3:0] host_off;
   wire hit;
   reg release_d;
   reg poll_service_d;
   // Host offsets are the low nibble of the flag addresses
   localparam [9:0] CMD_ADDR = `IO_CMD_FLAG_ADDR;
   localparam [9:0] STAT_ADDR = `IO_FLAG_STAT_ADDR;

   function mapped;
      input [7:0] a;
      begin
         mapped = (a[1:0] == 2'b00) && (a <= `REG_COAX_IN);
      end
   endfunction

   // ---------------------------------------------------------------
   // Sub blocks
   // ---------------------------------------------------------------
   host_write_catch u_catch (
      .clock(clock),
      .reset(reset),
      .host_wr(host_wr),
      .host_addr(host_addr),
      .release_lock(release_d),
      .pending_n_q(pend_n),
      .host_offset_q(host_off)
   );

   trigger_match u_trig (
      .clock(clock),
      .reset(reset),
      .trig_data(trig_data_q),
      .trig_mask(trig_mask_q),
      .screen_byte(screen_byte),
      .sample(refresh_tick),
      .hit(hit)
   );

   // ---------------------------------------------------------------
   // AXI4-Lite write path
   // ---------------------------------------------------------------
   // One write in flight: readies stay low until the response is taken
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
   wire wr_ctrl = wr_fire && (aw_addr_q == `REG_CTRL) && w_strb_q[0];
   wire wr_ctrl_hi = wr_fire && (aw_addr_q == `REG_CTRL) && w_strb_q[1];
   wire wr_irqs = wr_fire && (aw_addr_q == `REG_IRQ_STAT) && w_strb_q[0];

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         if (aw_take) begin
            aw_addr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (w_take) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         // Unmapped writes answer SLVERR and change nothing
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr_q) ? 2'b00 : 2'b10;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Config registers; trigger and attention setup come from AXI4-Lite register writes
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         trig_addr_q <= `RESET_BYTE;
         trig_data_q <= `RESET_BYTE;
         trig_mask_q <= `RESET_BYTE;
         attn_mask_q <= `RESET_BYTE;
         irq_mask_q <= 3'b000;
      end else if (wr_fire && w_strb_q[0]) begin
         case (aw_addr_q)
            `REG_TRIG_ADDR: trig_addr_q <= w_data_q[7:0];
            `REG_TRIG_DATA: trig_data_q <= w_data_q[7:0];
            `REG_ATTN_MASK: attn_mask_q <= w_data_q[7:0];
            `REG_IRQ_MASK: irq_mask_q <= w_data_q[2:0];
            default: irq_mask_q <= irq_mask_q;
         endcase
         if (aw_addr_q == `REG_TRIG_DATA && w_strb_q[1])
            trig_mask_q <= w_data_q[15:8];
      end
   end

   // ---------------------------------------------------------------
   // Host service: interrupt path or poll path, same effect
   // ---------------------------------------------------------------
   // The poll path shares the release strobe, so both give one effect
   always @* begin
      release_d = wr_ctrl && w_data_q[`CTRL_RELEASE];
      poll_service_d = release_d;
   end

   wire svc_cmd = poll_service_d && !pend_n && host_off == CMD_ADDR[3:0];
   wire svc_attn = poll_service_d && !pend_n && host_off == STAT_ADDR[3:0];

   // ---------------------------------------------------------------
   // Status refresh
   // ---------------------------------------------------------------
   // Fixed rate keeps status current without any host traffic
   assign refresh_tick = (refresh_q == `REFRESH_CYCLES - 8'd1);
   // Unused bit 7 dropped; polled bit from coax, rest from controller
   wire [7:0] aux_d = ((coax_main_status & `AUX_COAX_MASK) |
                       (controller_state_byte & ~`AUX_COAX_MASK)) & 8'h7F;
   wire [7:0] clr_main = wr_ctrl_hi ? w_data_q[15:8] : 8'h00;
   reg [7:0] main_d;

   always @* begin
      main_d = main_q & ~clr_main;
      if (aux_d != aux_q)
         main_d[`MS_AUX_CHANGE] = 1'b1;
      if (hit)
         main_d[`MS_TRIGGER] = 1'b1;
      main_d[`MS_KEY_EMPTY] = main_d[`MS_KEY_EMPTY] |
                              coax_main_status[`MS_KEY_EMPTY];
      main_d[`MS_UNIT_RESET] = main_d[`MS_UNIT_RESET] |
                               coax_main_status[`MS_UNIT_RESET];
      main_d[`MS_BUF_MOD] = main_d[`MS_BUF_MOD] |
                            coax_main_status[`MS_BUF_MOD];
      main_d[`MS_CURSOR_SET] = main_d[`MS_CURSOR_SET] |
                               coax_main_status[`MS_CURSOR_SET];
      main_d[`MS_FATAL] = 1'b0;
      main_d[`MS_CMD_IRQ] = 1'b0;
   end

   wire attn_set = refresh_tick && |(main_d & ~main_q & attn_mask_q);

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         refresh_q <= 8'h00;
         main_q <= `RESET_BYTE;
         aux_q <= `RESET_BYTE;
      end else begin
         refresh_q <= refresh_tick ? 8'h00 : refresh_q + 8'd1;
         if (refresh_tick) begin
            main_q <= main_d;
            aux_q <= aux_d;
         end else if (wr_ctrl_hi) begin
            main_q <= main_q & ~clr_main;
         end
      end
   end

   // ---------------------------------------------------------------
   // Flags, host read, outputs
   // ---------------------------------------------------------------
   wire cmd_done = wr_ctrl && w_data_q[`CTRL_CMD_DONE];

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         cmd_flag_q <= 1'b0;
         attn_flag_q <= 1'b0;
         pending_n_q <= 1'b1;
         host_lock_q <= 1'b0;
         host_rdata_q <= 8'h00;
         screen_addr_q <= 8'h00;
      end else begin
         // Set beats completion clear in the same cycle
         if (svc_cmd)
            cmd_flag_q <= 1'b1;
         else if (cmd_done)
            cmd_flag_q <= 1'b0;
         if (attn_set)
            attn_flag_q <= 1'b1;
         else if (svc_attn)
            attn_flag_q <= 1'b0;
         // Other offsets: lock release only
         pending_n_q <= pend_n;
         host_lock_q <= !pend_n && !release_d;
         // Trigger address leaves registered for the screen buffer
         screen_addr_q <= trig_addr_q;
         // Flags as they stood before this edge
         if (host_rd && host_addr == `IO_FLAG_STAT_ADDR)
            host_rdata_q <= {attn_flag_q, cmd_flag_q, 6'b000000};
      end
   end

   // ---------------------------------------------------------------
   // Interrupt status: lock, attention, command flag clear events
   // ---------------------------------------------------------------
   // Events: host block write pending, attention set, command done
   // The output copy lags the internal pending by one clock, marking its fall
   wire [2:0] ev;
   assign ev[0] = pending_n_q && !pend_n;
   assign ev[1] = attn_set;
   assign ev[2] = cmd_done;
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         irq_stat_q <= 3'b000;
         irq_q <= 1'b0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~(wr_irqs ? w_data_q[2:0] : 3'b000)) | ev;
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read path
   // ---------------------------------------------------------------
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      // Unmapped reads answer SLVERR with zero data
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
         case (s_axi_araddr)
            `REG_STATUS: s_axi_rdata <= {24'h000000, attn_flag_q, cmd_flag_q, 5'b00000, pend_n};
            `REG_MAIN: s_axi_rdata <= {24'h000000, main_q};
            `REG_AUX: s_axi_rdata <= {24'h000000, aux_q};
            `REG_TRIG_ADDR: s_axi_rdata <= {24'h000000, trig_addr_q};
            `REG_TRIG_DATA: s_axi_rdata <= {16'h0000, trig_mask_q, trig_data_q};
            `REG_ATTN_MASK: s_axi_rdata <= {24'h000000, attn_mask_q};
            `REG_IRQ_STAT: s_axi_rdata <= {29'h00000000, irq_stat_q};
            `REG_IRQ_MASK: s_axi_rdata <= {29'h00000000, irq_mask_q};
            `REG_HOST_ADDR: s_axi_rdata <= {28'h0000000, host_off};
            `REG_COAX_IN: s_axi_rdata <= {16'h0000, controller_state_byte, coax_main_status};
            default: s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: sim/host_flag_status_emulator_assertions.sv
// Checker for the host flag and status emulator ports
`timescale 1ns/1ps
`default_nettype none
module host_flag_status_emulator_assertions (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Host side
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [9:0] host_addr,
   input wire logic host_lock_q,
   input wire logic [7:0] host_rdata_q,
   // Flags and bus
   input wire logic cmd_flag_q,
   input wire logic attn_flag_q,
   input wire logic pending_n_q,
   input wire logic s_axi_bvalid
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   wire blk_wr = host_wr && (host_addr[9:4] == 6'h22);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   host_pend_a: assert property (
      blk_wr && pending_n_q && !host_lock_q |-> ##[1:3] !pending_n_q)
      else $error("block write not flagged");
   pend_src_a: assert property (
      $fell(pending_n_q) |-> $past(blk_wr, 2))
      else $error("pending without block write");
   lock_on_a: assert property (
      $fell(pending_n_q) |-> host_lock_q)
      else $error("host not locked out");
   lock_rel_a: assert property (
      $fell(host_lock_q) |-> ##[0:2] s_axi_bvalid)
      else $error("lockout dropped without register write");
   flag_read_a: assert property (
      host_rd && host_addr == 10'h227 |=>
      host_rdata_q == {$past(attn_flag_q), $past(cmd_flag_q), 6'h00})
      else $error("flag byte wrong");
   flag_zero_a: assert property (host_rdata_q[5:0] == 6'h00)
      else $error("unused flag bits set");
   cmd_set_a: assert property ($rose(cmd_flag_q) |-> !pending_n_q)
      else $error("command flag set without service");
   attn_clr_a: assert property ($fell(attn_flag_q) |-> !pending_n_q)
      else $error("attention cleared without service");
   cmd_clr_a: assert property (
      $fell(cmd_flag_q) |-> ##[0:2] s_axi_bvalid)
      else $error("command flag cleared without completion");
endmodule
bind host_flag_status_emulator host_flag_status_emulator_assertions u_chk (
   .clock(clock), .reset(reset), .host_wr(host_wr), .host_rd(host_rd),
   .host_addr(host_addr), .host_lock_q(host_lock_q), .host_rdata_q(host_rdata_q),
   .cmd_flag_q(cmd_flag_q), .attn_flag_q(attn_flag_q), .pending_n_q(pending_n_q),
   .s_axi_bvalid(s_axi_bvalid)
);
`default_nettype wire

// file: sim/host_pc_model.sv
// Host processor model on the I/O bus
`timescale 1ns/1ps
`default_nettype none
module host_pc_model (
   // Clock
   input wire logic clock,
   // Host bus
   input wire logic host_lock_q,
   output logic host_wr,
   output logic host_rd,
   output logic [9:0] host_addr
);
   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   initial begin
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_addr = 10'h000;
   end
   // No access while locked out; idle address flips so it is never stale
   task access(input logic wr, input logic [9:0] a);
      begin
         @(posedge clock);
         while (host_lock_q) @(posedge clock);
         host_wr <= wr;
         host_rd <= !wr;
         host_addr <= a;
         @(posedge clock);
         host_wr <= 1'b0;
         host_rd <= 1'b0;
         host_addr <= ~a;
      end
   endtask
endmodule
`default_nettype wire

// file: sim/host_flag_status_emulator_tb.sv
// Self-checking bench for the host flag and status emulator
`timescale 1ns/1ps
`default_nettype none
module host_flag_status_emulator_tb;
   // ----------------------------------------
   // Signals, models and tasks
   // ----------------------------------------
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [7:0] coax_main_status = 8'h00;
   logic [7:0] controller_state_byte = 8'h00;
   logic [7:0] screen_byte = 8'h00;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic [3:0] s_axi_wstrb = 4'hF;
   wire logic host_wr, host_rd, host_lock_q, cmd_flag_q, attn_flag_q, pending_n_q, irq_q;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [9:0] host_addr;
   wire logic [7:0] host_rdata_q, screen_addr_q;
   wire logic [1:0] s_axi_rresp, s_axi_bresp;
   wire logic [31:0] s_axi_rdata;
   logic [33:0] exp_q[$];
   logic [33:0] msk_q[$];
   integer seed = 72;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [3:0] o;
   logic [7:0] cx, cs, ms;
   always #2.5 clock = ~clock;
   host_flag_status_emulator u_dut (
      .clock(clock), .reset(reset), .host_wr(host_wr), .host_rd(host_rd),
      .host_addr(host_addr), .host_lock_q(host_lock_q), .host_rdata_q(host_rdata_q),
      .coax_main_status(coax_main_status), .controller_state_byte(controller_state_byte),
      .screen_byte(screen_byte), .screen_addr_q(screen_addr_q), .cmd_flag_q(cmd_flag_q),
      .attn_flag_q(attn_flag_q), .pending_n_q(pending_n_q), .irq_q(irq_q),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
   );
   host_pc_model u_host (.clock(clock), .host_lock_q(host_lock_q), .host_wr(host_wr),
      .host_rd(host_rd), .host_addr(host_addr));
   task wrap_up;
      begin
         if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk(input logic [7:0] g, input logic [7:0] e);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   task idle(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Entry waits an edge so a strobe is never assigned twice in one step
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic bd;
      begin
         @(posedge clock);
         bd = 1'b0;
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         while (!bd) begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
               bd = 1'b1;
               chk({6'h00, s_axi_bresp}, (a > 8'h28) ? 8'h02 : 8'h00);
            end
         end
         s_axi_bready <= 1'b0;
      end
   endtask
   task rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
      logic dn;
      begin
         @(posedge clock);
         dn = 1'b0;
         exp_q.push_back(e);
         msk_q.push_back(m);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         while (!dn) begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) dn = 1'b1;
         end
         s_axi_rready <= 1'b0;
      end
   endtask
   task ck(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      rd(a, {26'h0, e}, {26'h3000000, m});
   endtask
   // Read results checked against the oldest note; also cuts a hang short
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         wrap_up();
      end else if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
         cmp_count = cmp_count + 1;
         if ((({s_axi_rresp, s_axi_rdata} ^ exp_q[0]) & msk_q[0]) !== 34'h0) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t got %h exp %h", $time, s_axi_rdata, exp_q[0]);
         end
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      idle(16);
      reset <= 1'b0;
      ck(8'h04, 8'h01, 8'hC1);
      ck(8'h18, 8'h00, 8'hFF);
      wr(8'h20, 32'h1);
      u_host.access(1'b1, 10'h226);
      idle(4);
      chk({7'h0, irq_q}, 8'h01);
      ck(8'h04, 8'h00, 8'hC1);
      ck(8'h24, 8'h06, 8'h0F);
      wr(8'h00, 32'h1);
      ck(8'h04, 8'h41, 8'hC1);
      wr(8'h1C, 32'h7);
      idle(3);
      chk({7'h0, irq_q}, 8'h00);
      o = $random(seed);
      if (o[3:1] == 3'h3) o = o + 4'h2;
      u_host.access(1'b1, {6'h22, o});
      idle(4);
      ck(8'h24, {4'h0, o}, 8'h0F);
      wr(8'h00, 32'h1);
      ck(8'h04, 8'h41, 8'hC1);
      wr(8'h00, 32'h2);
      ck(8'h04, 8'h01, 8'hC1);
      cx = $random(seed);
      cs = $random(seed) | 8'h01;
      ms = {2'h2, cx[5], 1'b0, cx[3], 1'b0, cx[1:0]};
      coax_main_status <= cx;
      controller_state_byte <= cs;
      idle(40);
      ck(8'h0C, {1'b0, cx[6], cs[5:0]}, 8'hFF);
      ck(8'h08, ms, 8'hBF);
      coax_main_status <= 8'h00;
      idle(40);
      ck(8'h08, ms, 8'hBF);
      s_axi_wstrb <= 4'h1;
      wr(8'h00, 32'hFF00);
      s_axi_wstrb <= 4'hF;
      ck(8'h08, ms, 8'hBF);
      wr(8'h00, 32'hFF00);
      idle(40);
      ck(8'h08, 8'h00, 8'hBF);
      wr(8'h10, 32'h12);
      wr(8'h14, 32'hFFA5);
      screen_byte <= 8'h5A;
      idle(40);
      wr(8'h00, 32'hFF00);
      idle(40);
      ck(8'h08, 8'h00, 8'h40);
      chk(screen_addr_q, 8'h12);
      screen_byte <= 8'hA5;
      idle(40);
      ck(8'h08, 8'h40, 8'h40);
      wr(8'h14, 32'h0);
      idle(40);
      wr(8'h00, 32'hFF00);
      idle(40);
      ck(8'h08, 8'h00, 8'h40);
      screen_byte <= 8'h3C;
      idle(40);
      ck(8'h08, 8'h40, 8'h40);
      wr(8'h18, 32'h08);
      wr(8'h20, 32'h2);
      coax_main_status <= 8'h08;
      idle(40);
      ck(8'h04, 8'h81, 8'hC1);
      chk({7'h0, irq_q}, 8'h01);
      u_host.access(1'b0, 10'h227);
      idle(2);
      chk(host_rdata_q, 8'h80);
      u_host.access(1'b1, 10'h227);
      idle(4);
      wr(8'h00, 32'h1);
      ck(8'h04, 8'h01, 8'hC1);
      wr(8'h3C, 32'hFFFFFFFF);
      ck(8'h18, 8'h08, 8'hFF);
      rd(8'h3C, {2'h2, 32'h0}, {2'h3, 32'hFFFFFFFF});
      idle(5);
      wrap_up();
   end
endmodule
`default_nettype wire
